/* File: pkg/sad_map.svh */
// Numeric map of the serial converter control block: frame edge counts and sizes.
// Assumes inclusion by bare name from the package, the core and the bench; the FIFO does not include it.
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH

// ==========================================================================
// Result word and FIFO sizes
// ==========================================================================
`define SAD_RES_BITS 16
`define SAD_FIFO_DEPTH 8

// ==========================================================================
// Falling-edge positions inside one frame, counted from the select's fall
// ==========================================================================
`define SAD_CNT_BITS 6
`define SAD_NULL_EDGE 6'd5
`define SAD_LSB_EDGE 6'd21
`define SAD_LAST_EDGE 6'd36
`define SAD_CNT_ONE 6'd1

// Decision time per bit at full throughput, kept for reference; the bench does not use it.
`define SAD_DECISION_TIME_NS 167

`endif

/* File: pkg/sad_pkg.sv */
// Types shared by the serial converter control block.
// Assumes the map header is on the include path.
`include "sad_map.svh"

package sad_pkg;

  // ========================================================================
  // Frame phases on the serial bit clock
  // ========================================================================
  typedef enum logic [2:0] {
    SAD_PH_SAMPLE,
    SAD_PH_MSB_FIRST,
    SAD_PH_LSB_FIRST,
    SAD_PH_DONE
  } sad_phase_t;

  // State that lives only while the select is low.
  typedef struct packed {
    sad_phase_t phase;
    logic [`SAD_CNT_BITS-1:0] cnt;
    logic [`SAD_RES_BITS-1:0] word;
    logic dout;
    logic dout_oe;
    logic analog_on;
    logic digital_on;
  } sad_frame_t;

  // Link-clock state that must survive between frames.
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
  } sad_keep_t;

  // System-clock state.
  typedef struct packed {
    logic [`SAD_RES_BITS-1:0] hold;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic busy_s1;
    logic busy_s2;
    logic dig_s1;
    logic dig_s2;
  } sad_sys_t;

endpackage

/* File: logic/sad_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sad_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // Elaboration check
  // ========================================================================
  // Pointers wrap naturally, so only powers of two are served.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sad_fifo: DEPTH must be a power of two of at least 2.");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sad_fptr_t;

  sad_fptr_t cur_ff;
  sad_fptr_t nxt_cur;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push;
  logic pop;

  // Full and empty come from the extra pointer bit, so all entries are usable.
  assign in_ready = (cur_ff.wp[AW-1:0] != cur_ff.rp[AW-1:0]) || (cur_ff.wp[AW] == cur_ff.rp[AW]);
  assign out_valid = (cur_ff.wp != cur_ff.rp);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[cur_ff.rp[AW-1:0]];

  // Pointer update.
  always_comb begin
    nxt_cur = cur_ff;
    if (push) begin
      nxt_cur.wp = cur_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_cur.rp = cur_ff.rp + 1'b1;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Storage has no reset; an entry is only read after it was written.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[cur_ff.wp[AW-1:0]] <= in_data;
    end
  end

endmodule // sad_fifo

`default_nettype wire

/* File: logic/sad_core.sv */
// Digital control of a serial successive-approximation converter frame.
// Assumes results arrive on clk_sys; the host drives select and bit clock.
`timescale 1ns/1ps
`default_nettype none
`include "sad_map.svh"

// What this block does
// - Power down when a conversion finishes and whenever the select is high.
// - Select still low after finish: only analog turns off, digital keeps clocking.
// - Digital section is off while select is high, and stays off after select falls until the first falling clock edge.
// - Each result bit appears on the data output as soon as decided.
// - Host may raise select anytime; the cycle aborts and powers down.
// - One result bit per bit-clock cycle, output updated within that cycle.
// - Select falling starts conversion; first five clock periods sample the input.
// - After fifth falling edge drive low one period, then 16 bits MSB first.
// - Then repeat LSB first; after MSB repeated, tri-state and ignore clocks.
// - New conversion only after select went high and then low again.
module sad_core
  import sad_pkg::*;
#(
  parameter int RES_BITS = `SAD_RES_BITS,
  parameter int FIFO_DEPTH = `SAD_FIFO_DEPTH
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Result words from the converter array.
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [RES_BITS-1:0] res_data,
  // System-side status.
  output logic conv_busy,
  output logic digital_awake,
  output logic word_pending,
  // Host pins.
  input wire logic cs_n,
  input wire logic serial_bit_clock,
  output logic dout_o,
  output logic dout_oe,
  // Power controls in the link domain.
  output logic analog_on,
  output logic digital_on
);

  // ========================================================================
  // Elaboration check
  // ========================================================================
  // Frame edge counts are fixed for a sixteen-bit word.
  if (RES_BITS != `SAD_RES_BITS) begin : g_bad_width
    $error("sad_core: RES_BITS must match the frame layout.");
  end

  sad_sys_t sys_ff;
  sad_sys_t nxt_sys;
  sad_frame_t frm_ff;
  sad_frame_t nxt_frm;
  sad_keep_t keep_ff;
  sad_keep_t nxt_keep;
  logic fifo_valid;
  logic fifo_ready;
  logic [RES_BITS-1:0] fifo_data;
  logic sys_pending;
  logic link_pending;
  logic frame_rst_n;
  logic [`SAD_CNT_BITS-1:0] edge_no;
  logic [`SAD_CNT_BITS-1:0] msb_idx;
  logic [`SAD_CNT_BITS-1:0] lsb_idx;

  // ========================================================================
  // Result buffer on the system clock
  // ========================================================================
  sad_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data)
  );

  // The holding word may only change while no request is outstanding, which
  // keeps it stable for the whole time the link side may sample it.
  assign sys_pending = (sys_ff.req != sys_ff.ack_s2);
  assign fifo_ready = !sys_pending;

  // ========================================================================
  // System-clock state
  // ========================================================================
  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.ack_s1 = keep_ff.ack;
    nxt_sys.ack_s2 = sys_ff.ack_s1;
    nxt_sys.busy_s1 = frm_ff.analog_on;
    nxt_sys.busy_s2 = sys_ff.busy_s1;
    nxt_sys.dig_s1 = frm_ff.digital_on;
    nxt_sys.dig_s2 = sys_ff.dig_s1;
    if (!sys_pending && fifo_valid) begin
      nxt_sys.hold = fifo_data;
      nxt_sys.req = !sys_ff.req;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign conv_busy = sys_ff.busy_s2;
  assign digital_awake = sys_ff.dig_s2;
  assign word_pending = sys_pending;

  // ========================================================================
  // Link-side frame logic on falling bit-clock edges
  // ========================================================================
  // A high select holds the frame logic in reset, so clocks are ignored, the
  // output floats and the digital section is off; releasing it is the only
  // way a new frame begins.
  assign frame_rst_n = arst_n && !cs_n;

  assign link_pending = (keep_ff.req_s2 != keep_ff.ack);
  assign edge_no = frm_ff.cnt + `SAD_CNT_ONE;
  assign msb_idx = `SAD_LSB_EDGE - edge_no;
  assign lsb_idx = edge_no - `SAD_LSB_EDGE;

  // Next frame and keep state; one bit is resolved per clock.
  always_comb begin
    nxt_frm = frm_ff;
    nxt_keep = keep_ff;
    nxt_keep.req_s1 = sys_ff.req;
    nxt_keep.req_s2 = keep_ff.req_s1;
    nxt_frm.digital_on = 1'b1;
    case (frm_ff.phase)
      SAD_PH_SAMPLE: begin
        nxt_frm.cnt = edge_no;
        nxt_frm.analog_on = 1'b1;
        if (edge_no == `SAD_NULL_EDGE) begin
          // Null bit, and the word is taken once the sampling window closes.
          nxt_frm.dout_oe = 1'b1;
          nxt_frm.dout = 1'b0;
          nxt_frm.phase = SAD_PH_MSB_FIRST;
          if (link_pending) begin
            nxt_frm.word = sys_ff.hold;
            nxt_keep.ack = !keep_ff.ack;
          end else begin
            nxt_frm.word = '0;
          end
        end
      end
      SAD_PH_MSB_FIRST: begin
        nxt_frm.cnt = edge_no;
        nxt_frm.dout = frm_ff.word[msb_idx[3:0]];
        if (edge_no == `SAD_LSB_EDGE) begin
          // Last decision made: the analog section powers down here.
          nxt_frm.analog_on = 1'b0;
          nxt_frm.phase = SAD_PH_LSB_FIRST;
        end
      end
      SAD_PH_LSB_FIRST: begin
        nxt_frm.cnt = edge_no;
        nxt_frm.dout = frm_ff.word[lsb_idx[3:0]];
        if (edge_no == `SAD_LAST_EDGE) begin
          nxt_frm.phase = SAD_PH_DONE;
        end
      end
      SAD_PH_DONE: begin
        // Further clocks have no effect beyond floating the output.
        nxt_frm.dout_oe = 1'b0;
        nxt_frm.dout = 1'b0;
      end
      default: begin
        nxt_frm.phase = SAD_PH_DONE;
        nxt_frm.dout_oe = 1'b0;
      end
    endcase
  end

  // Frame registers: cleared by reset or by a high select.
  always_ff @(negedge serial_bit_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frm_ff <= '0;
    end else begin
      frm_ff <= nxt_frm;
    end
  end

  // Handshake registers survive between frames; only the main reset clears them.
  always_ff @(negedge serial_bit_clock or negedge arst_n) begin
    if (!arst_n) begin
      keep_ff <= '0;
    end else begin
      keep_ff <= nxt_keep;
    end
  end

  assign dout_o = frm_ff.dout;
  assign dout_oe = frm_ff.dout_oe;
  assign analog_on = frm_ff.analog_on;
  assign digital_on = frm_ff.digital_on;

endmodule // sad_core

`default_nettype wire

/* File: testbench/sad_chk.sv */
// Checker for the converter frame pins, bound to the core's top ports.
// Assumes the bit clock stands still between frames, so idle checks use clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sad_chk (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host pins.
  input wire logic cs_n,
  input wire logic serial_bit_clock,
  input wire logic dout_o,
  input wire logic dout_oe,
  // Power controls.
  input wire logic analog_on,
  input wire logic digital_on
);
  logic [5:0] edge_ff;
  // ========================================
  // Edge count, cleared by select high just as the frame logic is.
  always_ff @(negedge serial_bit_clock or posedge cs_n or negedge arst_n) begin
    if (!arst_n || cs_n) begin
      edge_ff <= 6'h00;
    end else if (edge_ff != 6'h3F) begin
      edge_ff <= edge_ff + 6'h01;
    end
  end
  // ========================================
  // Sampled values at an edge show the state left by the previous edge.
  sequence s_null;
    dout_oe && !dout_o;
  endsequence
  sequence s_rep_b1;
    dout_oe && (dout_o == $past(dout_o, 2));
  endsequence
  property p_sample;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n)
    (edge_ff >= 6'h01 && edge_ff <= 6'h04) |-> (!dout_oe && analog_on && digital_on);
  endproperty
  property p_null;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n) (edge_ff == 6'h05) |-> s_null;
  endproperty
  property p_bits;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n)
    (edge_ff >= 6'h06 && edge_ff <= 6'h24) |-> dout_oe;
  endproperty
  property p_rep_first;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n) (edge_ff == 6'h16) |-> s_rep_b1;
  endproperty
  property p_rep_last;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n)
    (edge_ff == 6'h24) |-> (dout_o == $past(dout_o, 30));
  endproperty
  property p_done;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n) (edge_ff >= 6'h25) |-> !dout_oe;
  endproperty
  property p_analog_off;
    @(negedge serial_bit_clock) disable iff (!arst_n || cs_n)
    (edge_ff >= 6'h15) |-> (!analog_on && digital_on);
  endproperty
  property p_idle_tri;
    @(posedge clk_sys) disable iff (!arst_n) cs_n |-> !dout_oe;
  endproperty
  property p_full_down;
    @(posedge clk_sys) disable iff (!arst_n) cs_n |-> (!digital_on && !analog_on);
  endproperty
  a_sample: assert property (p_sample) else $error("sampling phase wrong");
  a_null: assert property (p_null) else $error("null bit wrong");
  a_bits: assert property (p_bits) else $error("data pin released early");
  a_rep_first: assert property (p_rep_first) else $error("repeat start wrong");
  a_rep_last: assert property (p_rep_last) else $error("repeat end wrong");
  a_done: assert property (p_done) else $error("pin not released");
  a_analog_off: assert property (p_analog_off) else $error("power state wrong");
  a_idle_tri: assert property (p_idle_tri) else $error("pin driven in idle");
  a_full_down: assert property (p_full_down) else $error("not powered down");
endmodule // sad_chk
bind sad_core sad_chk chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n),
  .serial_bit_clock(serial_bit_clock), .dout_o(dout_o), .dout_oe(dout_oe),
  .analog_on(analog_on), .digital_on(digital_on));
`default_nettype wire

/* File: testbench/sad_host_mdl.sv */
// Host model: drives select and a 6 ns bit clock, records pins after each fall.
// Assumes the bench calls its tasks by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module sad_host_mdl (
  // Host pins.
  output logic cs_n,
  output logic serial_bit_clock,
  input wire logic dout_o,
  input wire logic dout_oe,
  // Power controls seen for the record.
  input wire logic analog_on
);
  logic [40:0] cap_d;
  logic [40:0] cap_oe;
  logic [40:0] cap_an;
  logic line;
  // No pull resistor: a released line shows the inverse of dout_o, not the last bit.
  always_comb line = dout_oe ? dout_o : ~dout_o;
  initial begin
    cs_n = 1'b1; // Select high from power-up.
    serial_bit_clock = 1'b0;
  end
  // The clock runs only inside the frame, fast; select stays low until end_frame.
  task automatic run_frame(input int edges);
    #1.3 cs_n = 1'b0;
    for (int k = 1; k <= edges; k++) begin
      #2 serial_bit_clock = 1'b1;
      #3 serial_bit_clock = 1'b0;
      #1;
      cap_d[k] = line;
      cap_oe[k] = dout_oe;
      cap_an[k] = analog_on;
    end
  endtask
  // Raising select may cut any frame short.
  task automatic end_frame();
    #2 cs_n = 1'b1;
    #2;
  endtask
endmodule // sad_host_mdl
`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench for the converter frame control core.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sad_map.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic res_valid = 1'b0;
  logic [`SAD_RES_BITS-1:0] res_data = 16'h0000;
  logic res_ready, conv_busy, digital_awake, word_pending;
  logic cs_n, serial_bit_clock, dout_o, dout_oe, analog_on, digital_on;
  int failures = 0;
  int checks = 0;
  always #50 clk_sys = ~clk_sys;
  sad_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .conv_busy(conv_busy),
    .digital_awake(digital_awake), .word_pending(word_pending), .cs_n(cs_n),
    .serial_bit_clock(serial_bit_clock), .dout_o(dout_o), .dout_oe(dout_oe),
    .analog_on(analog_on), .digital_on(digital_on));
  sad_host_mdl host_u (.cs_n(cs_n), .serial_bit_clock(serial_bit_clock),
    .dout_o(dout_o), .dout_oe(dout_oe), .analog_on(analog_on));
  // ========================================
  // Comparison and verdict.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The old word may still show pending until the ack returns, so wait first.
  task automatic wait_pending();
    int n;
    n = 0;
    repeat (4) @(negedge clk_sys);
    while (word_pending !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("ERROR %0t no word pending", $time);
      results();
    end
  endtask
  task automatic push(input logic [15:0] w);
    @(negedge clk_sys);
    res_valid = 1'b1;
    res_data = w;
    @(negedge clk_sys);
    res_valid = 1'b0;
  endtask
  task automatic check_frame(input logic [15:0] w, input int edges);
    logic eoe;
    logic ed;
    for (int k = 1; k <= edges; k++) begin
      eoe = (k >= 5 && k <= 36);
      ed = (k >= 6 && k <= 21) ? w[21-k] : (k >= 22 && k <= 36) ? w[k-21] : 1'b0;
      chk1(host_u.cap_oe[k], eoe);
      if (eoe) chk1(host_u.cap_d[k], ed);
    end
  endtask
  // ========================================
  // Scenarios.
  task automatic t_full();
    push(16'hA5C3);
    wait_pending();
    host_u.run_frame(40);
    check_frame(16'hA5C3, 40);
    chk1(host_u.cap_an[1], 1'b1);
    chk1(host_u.cap_an[20], 1'b1);
    chk1(host_u.cap_an[21], 1'b0);
    chk1(digital_on, 1'b1);
    repeat (3) @(negedge clk_sys);
    chk1(digital_awake, 1'b1);
    chk1(conv_busy, 1'b0);
    host_u.end_frame();
    chk1(digital_on, 1'b0);
    repeat (3) @(negedge clk_sys);
    chk1(digital_awake, 1'b0);
  endtask
  task automatic t_short();
    push(16'h9A6D);
    wait_pending();
    host_u.run_frame(19);
    check_frame(16'h9A6D, 19);
    // The clock is stopped before the last decision, so the analog side stays on.
    repeat (3) @(negedge clk_sys);
    chk1(conv_busy, 1'b1);
    host_u.end_frame();
    chk1(dout_oe, 1'b0);
    chk1(analog_on, 1'b0);
    chk1(digital_on, 1'b0);
  endtask
  // Fill until refused with no frames running, then drain in order.
  task automatic t_fill();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (res_ready === 1'b1 && n < 12) begin
      res_valid = 1'b1;
      res_data = 16'h3C00 + 16'(n);
      n++;
      @(negedge clk_sys);
    end
    res_valid = 1'b0;
    check(16'(n), 16'h0009); // Eight stored plus the holding word.
    for (int i = 0; i < n; i++) begin
      wait_pending();
      host_u.run_frame(22);
      host_u.end_frame();
      check_frame(16'h3C00 + 16'(i), 22);
    end
    chk1(res_ready, 1'b1);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    chk1(res_ready, 1'b1);
    chk1(dout_oe, 1'b0);
    chk1(word_pending, 1'b0);
    t_full();
    t_short();
    t_fill();
    results();
  end
endmodule // tb_top
`default_nettype wire
